// ---- rtl/accessory_irq_timing_regs.sv ----
`timescale 1ns/1ns
`default_nettype none

module accessory_irq_timing_regs #(
    parameter int TICK_CYCLES = accessory_regs_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Two-wire bus pins, sampled synchronously
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // First-register event sources and masked report
    input wire logic [7:0] first_src,
    output logic [7:0] first_report,
    // Second-register event sources
    input wire accessory_regs_pkg::second_src_t second_src,
    input wire logic adc_irq_disable,
    output logic second_pending,
    // Resistance detection
    input wire logic adc_start,
    input wire logic [4:0] adc_sample,
    // Timer starts and ends: 0 key press, 1 long key, 2 switch wait
    input wire logic [2:0] timing_start,
    output logic [2:0] timing_done
);

    // Bus front end
    logic scl_q; // Previous clock line sample
    logic sda_q; // Previous data line sample
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    accessory_regs_pkg::slave_state_t state; // Slave state
    logic [3:0] bit_cnt; // Bits seen in the current byte
    logic [7:0] shift; // Byte shift register
    logic is_read; // Direction of the current transfer
    logic have_ptr; // Pointer byte already received
    logic ack_ok; // Master acked the last read byte
    logic [7:0] ptr; // Register pointer, auto-increment
    logic byte_end; // Falling clock after eighth bit
    logic addr_hit; // Address byte matches
    logic wr_strobe; // Data byte to register
    logic rd_load; // Fetch of the next read byte

    // Registers
    logic [7:0] second_flags;
    logic [7:0] first_masks;
    logic [7:0] second_masks;
    logic [7:0] id_code;
    logic [7:0] key_detect_timing;
    logic [7:0] wait_longkey_timing;

    // Decode and read mux
    logic sel_flags, sel_m1, sel_m2, sel_id, sel_t1, sel_t2;
    logic [7:0] rd_data;
    logic [7:0] flag_set; // Hardware set terms, after masking
    logic [7:0] flag_clr; // Clear-on-read term
    logic adc_done; // Detection interval elapsed

    // Timers
    logic [15:0] tick_cnt;
    logic tick;
    logic [3:0] tmr_start;
    logic [3:0] tmr_done;
    logic [15:0] tmr_codes;

    assign sda_out = 1'b0; // Open drain: only ever pulls low

    // Edge and condition detection on the sampled lines
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_det = scl_in && scl_q && sda_q && !sda_in;
    assign stop_det = scl_in && scl_q && !sda_q && sda_in;
    assign byte_end = scl_fall && (bit_cnt == 4'h8);
    assign addr_hit = (shift[7:1] == accessory_regs_pkg::BUS_ADDR);
    assign wr_strobe = (state == accessory_regs_pkg::ST_WDATA) && byte_end;
    assign rd_load = scl_fall && (((state == accessory_regs_pkg::ST_ACK_ADDR) && is_read)
                     || ((state == accessory_regs_pkg::ST_RACK) && ack_ok));

    // Address decode
    assign sel_flags = (ptr == accessory_regs_pkg::OFS_SECOND_FLAGS);
    assign sel_m1 = (ptr == accessory_regs_pkg::OFS_FIRST_MASKS);
    assign sel_m2 = (ptr == accessory_regs_pkg::OFS_SECOND_MASKS);
    assign sel_id = (ptr == accessory_regs_pkg::OFS_ID_CODE);
    assign sel_t1 = (ptr == accessory_regs_pkg::OFS_KEY_DETECT_TIMING);
    assign sel_t2 = (ptr == accessory_regs_pkg::OFS_WAIT_LONGKEY_TIMING);

    // Unmapped offsets read as zero
    assign rd_data = ({8{sel_flags}} & second_flags) | ({8{sel_m1}} & first_masks)
                   | ({8{sel_m2}} & second_masks) | ({8{sel_id}} & id_code)
                   | ({8{sel_t1}} & key_detect_timing) | ({8{sel_t2}} & wait_longkey_timing);

    // Line history for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Bus slave sequencing; no clock stretching, so reads are fetched
    // on the falling clock edge right before the first bit is due
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= accessory_regs_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            is_read <= 1'b0;
            have_ptr <= 1'b0;
            ack_ok <= 1'b0;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                // Start or repeated start restarts address phase
                state <= accessory_regs_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
                have_ptr <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= accessory_regs_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (rd_load) begin
                // Load next read byte and drive its first bit
                state <= accessory_regs_pkg::ST_RDATA;
                shift <= rd_data;
                sda_oe <= !rd_data[7];
                bit_cnt <= 4'h0;
                ptr <= ptr + 8'h01;
            end else begin
                case (state)
                    accessory_regs_pkg::ST_ADDR, accessory_regs_pkg::ST_WDATA: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_end) begin
                            if (state == accessory_regs_pkg::ST_WDATA) begin
                                // Data byte acked; first one sets the pointer
                                state <= accessory_regs_pkg::ST_ACK_W;
                                sda_oe <= 1'b1;
                                have_ptr <= 1'b1;
                                ptr <= have_ptr ? ptr + 8'h01 : shift;
                            end else if (addr_hit) begin
                                state <= accessory_regs_pkg::ST_ACK_ADDR;
                                is_read <= shift[0];
                                sda_oe <= 1'b1;
                            end else begin
                                // Not ours: stay off the bus until next start
                                state <= accessory_regs_pkg::ST_IDLE;
                            end
                        end
                    end
                    accessory_regs_pkg::ST_ACK_ADDR, accessory_regs_pkg::ST_ACK_W: begin
                        // Release acknowledge, take a written byte next
                        if (scl_fall) begin
                            state <= accessory_regs_pkg::ST_WDATA;
                            sda_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                        end
                    end
                    accessory_regs_pkg::ST_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_end) begin
                            state <= accessory_regs_pkg::ST_RACK;
                            sda_oe <= 1'b0;
                        end else if (scl_fall) begin
                            shift <= {shift[6:0], 1'b0};
                            sda_oe <= !shift[6];
                        end
                    end
                    accessory_regs_pkg::ST_RACK: begin
                        // Master acknowledge; a nack ends the read
                        if (scl_rise) begin
                            ack_ok <= !sda_in;
                        end else if (scl_fall) begin
                            state <= accessory_regs_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state <= accessory_regs_pkg::ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Second flag set terms; masked sources never set their flag
    always_comb begin
        flag_set = 8'h00;
        flag_set[accessory_regs_pkg::BIT_STUCK_RECOVER] = second_src.stuck_recover;
        flag_set[accessory_regs_pkg::BIT_STUCK_KEY] = second_src.stuck_key;
        flag_set[accessory_regs_pkg::BIT_ADC_CHANGE] = adc_done && !adc_irq_disable;
        flag_set[accessory_regs_pkg::BIT_RSV_ATTACH] = second_src.rsv_attach;
        flag_set = flag_set & ~second_masks & accessory_regs_pkg::SECOND_USED;
    end

    // A read fetch of the flag register clears it
    assign flag_clr = {8{rd_load && sel_flags}};
    assign second_pending = |second_flags;

    // Flag register: set beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            second_flags <= accessory_regs_pkg::RST_SECOND_FLAGS;
        end else if (ce) begin
            second_flags <= (second_flags & ~flag_clr) | flag_set;
        end
    end

    // Writable registers; flag and code registers ignore writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            first_masks <= accessory_regs_pkg::RST_MASKS;
            second_masks <= accessory_regs_pkg::RST_MASKS;
            key_detect_timing <= accessory_regs_pkg::RST_TIMING;
            wait_longkey_timing <= accessory_regs_pkg::RST_TIMING;
        end else if (ce && wr_strobe && have_ptr) begin
            if (sel_m1) begin
                first_masks <= shift;
            end
            if (sel_m2) begin
                // Reserved bits are not stored and read as zero
                second_masks <= shift & accessory_regs_pkg::SECOND_USED;
            end
            if (sel_t1) begin
                key_detect_timing <= shift;
            end
            if (sel_t2) begin
                wait_longkey_timing <= shift;
            end
        end
    end

    // Detected code is captured when the detection interval ends
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            id_code <= accessory_regs_pkg::RST_ID_CODE;
        end else if (ce && adc_done) begin
            id_code <= {3'b000, adc_sample};
        end
    end

    // Masked first-register report, registered
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            first_report <= 8'h00;
        end else if (ce) begin
            first_report <= first_src & ~first_masks;
        end
    end

    // Shared millisecond prescaler keeps the per-channel counters small
    assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_cnt <= 16'h0000;
        end else if (ce) begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // Timing field selection per channel
    assign tmr_start = {timing_start, adc_start};
    assign tmr_codes = {wait_longkey_timing[7:4], wait_longkey_timing[3:0],
                        key_detect_timing[7:4], key_detect_timing[3:0]};
    assign adc_done = tmr_done[0];
    assign timing_done = tmr_done[3:1];

    // One interval timer per timing field
    for (genvar ch = 0; ch < accessory_regs_pkg::TIMER_CHANNELS; ch++) begin : g_tmr
        interval_timer u_tmr (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .tick(tick),
            .start(tmr_start[ch]),
            .code(tmr_codes[ch*4 +: 4]),
            .done(tmr_done[ch])
        );
    end

endmodule

`default_nettype wire

// ---- rtl/accessory_regs_pkg.sv ----
`default_nettype none

package accessory_regs_pkg;

    // Seven-bit bus address of the device
    localparam logic [6:0] BUS_ADDR = 7'h25;

    // Register offsets, byte addressed
    localparam logic [7:0] OFS_SECOND_FLAGS = 8'h04;
    localparam logic [7:0] OFS_FIRST_MASKS = 8'h05;
    localparam logic [7:0] OFS_SECOND_MASKS = 8'h06;
    localparam logic [7:0] OFS_ID_CODE = 8'h07;
    localparam logic [7:0] OFS_KEY_DETECT_TIMING = 8'h08;
    localparam logic [7:0] OFS_WAIT_LONGKEY_TIMING = 8'h09;

    // Reset values
    localparam logic [7:0] RST_SECOND_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASKS = 8'h00;
    localparam logic [7:0] RST_ID_CODE = 8'h1f;
    localparam logic [7:0] RST_TIMING = 8'h00;

    // Field positions of the second flag and mask registers
    localparam int BIT_STUCK_RECOVER = 4;
    localparam int BIT_STUCK_KEY = 3;
    localparam int BIT_ADC_CHANGE = 2;
    localparam int BIT_RSV_ATTACH = 1;
    localparam logic [7:0] SECOND_USED = 8'h1e;

    // Width of the resistance code field
    localparam int ID_CODE_BITS = 5;

    // Timing fields: upper nibble and lower nibble
    localparam int TIMING_HI_LSB = 4;
    localparam int TIMING_CODE_BITS = 4;

    // Timer channels: 0 detection, 1 key press, 2 long key, 3 switch wait
    localparam int TIMER_CHANNELS = 4;

    // Clock rate and millisecond tick
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Duration per timing code, in milliseconds, code 0 in the low slot
    localparam logic [255:0] DUR_MS_TABLE = {
        16'h0320, 16'h02ee, 16'h02bc, 16'h028a, 16'h0258, 16'h0226, 16'h01f4, 16'h01c2,
        16'h0190, 16'h015e, 16'h012c, 16'h00fa, 16'h00c8, 16'h0096, 16'h0064, 16'h0032
    };

    // Bus slave states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b011,
        ST_WDATA = 3'b010,
        ST_ACK_W = 3'b110,
        ST_RDATA = 3'b111,
        ST_RACK = 3'b101
    } slave_state_t;

    // Raw second-register event sources
    typedef struct packed {
        logic stuck_recover;
        logic stuck_key;
        logic rsv_attach;
    } second_src_t;

endpackage

`default_nettype wire

// ---- rtl/interval_timer.sv ----
`timescale 1ns/1ns
`default_nettype none

module interval_timer (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Millisecond tick from the shared prescaler
    input wire logic tick,
    // Start request and duration code
    input wire logic start,
    input wire logic [3:0] code,
    // One-cycle pulse when the interval has run out
    output logic done
);

    logic [15:0] remain; // Milliseconds still to go, zero when idle
    logic [15:0] dur_ms; // Looked-up duration
    logic last_tick; // Final tick of a running interval

    // Code to duration through the fixed table
    assign dur_ms = accessory_regs_pkg::DUR_MS_TABLE[{code, 4'h0} +: 16];
    assign last_tick = tick && (remain == 16'h0001);

    // Down counter; a new start restarts the interval.
    // Accuracy is one tick, since the first tick may come early.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            remain <= 16'h0000;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                remain <= dur_ms;
            end else if (tick && remain != 16'h0000) begin
                remain <= remain - 16'h0001;
                done <= last_tick;
            end
        end
    end

endmodule

`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Host processor stand-in: bus master on open-drain lines
module host_model (
    // Clock and resolved data line
    input wire logic sys_clk,
    input wire logic sda_line,
    // High pulls data low; the bus clock rests high between frames
    output logic scl,
    output logic sda_low,
    // One-cycle strobe with each byte read
    output logic rd_valid,
    output logic [7:0] rd_byte
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_byte = 8'h00;
    end
    // One phase of four cycles, so the sampler sees every level settle
    task automatic step(input logic c, input logic low);
        scl = c;
        sda_low = low;
        repeat (4) @(negedge sys_clk);
    endtask
    // Start or repeated start, from idle or with the clock low
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    // Data moves only while the clock is low, never with a clock edge
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, !b);
        step(1'b1, !b);
        s = sda_line;
        step(1'b0, !b);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // A nack on the last byte makes the device let go of the line
    task automatic get(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(last, s);
        rd_byte = b;
        rd_valid = 1'b1;
        @(negedge sys_clk);
        rd_valid = 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- dv/accessory_regs_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

// Port-level watcher of the register block
module accessory_regs_chk #(
    parameter int TICK_CYCLES = 4
) (
    // Clock, reset, enable and bus
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Events, detection and timers
    input wire logic [7:0] first_src,
    input wire logic [7:0] first_report,
    input wire accessory_regs_pkg::second_src_t second_src,
    input wire logic adc_irq_disable,
    input wire logic second_pending,
    input wire logic adc_start,
    input wire logic [4:0] adc_sample,
    input wire logic [2:0] timing_start,
    input wire logic [2:0] timing_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Quiet outputs on the first cycle out of reset
    reset_quiet_a: assert property ($rose(rst_n) |-> !sda_oe && !second_pending
        && first_report == 8'h00 && timing_done == 3'h0) else $error("outputs busy after reset");
    // A report needs its source one cycle earlier
    report_cause_a: assert property ($past(ce) |-> (first_report & ~$past(first_src)) == 8'h00)
        else $error("first report without source");
    // Interval ends are single pulses and come no sooner than eight cycles after a start
    done_pulse_a: assert property ((timing_done & $past(timing_done)) == 3'h0)
        else $error("timer end longer than one cycle");
    key_press_min_a: assert property (timing_start[0] |=> !timing_done[0] [*8])
        else $error("key press interval too short");
    long_key_min_a: assert property (timing_start[1] |=> !timing_done[1] [*8])
        else $error("long key interval too short");
    switch_wait_min_a: assert property (timing_start[2] |=> !timing_done[2] [*8])
        else $error("switch wait interval too short");
    // Device moves data only while the bus clock is low
    data_move_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved with clock high");
    open_drain_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    // Flags clear only inside a bus read
    flag_clear_a: assert property ($fell(second_pending) |-> !scl_in)
        else $error("flags cleared outside a read");
    // With detection interrupts off, only stuck or attach events raise a flag
    adc_block_a: assert property ($rose(second_pending) |->
        ($past(second_src) != 3'b000 || !$past(adc_irq_disable))) else $error("blocked flag raised");
    cover property (timing_done[2]);
    cover property ($fell(second_pending));
    cover property (first_report != 8'h00);
endmodule

bind accessory_irq_timing_regs accessory_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .first_src(first_src), .first_report(first_report),
    .second_src(second_src), .adc_irq_disable(adc_irq_disable),
    .second_pending(second_pending), .adc_start(adc_start), .adc_sample(adc_sample),
    .timing_start(timing_start), .timing_done(timing_done)
);

`default_nettype wire

// ---- dv/accessory_irq_timing_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module accessory_irq_timing_regs_tb;
    localparam int TICK = 4; // Short tick keeps intervals between 200 and 3200 cycles
    localparam logic [7:0] WR = {accessory_regs_pkg::BUS_ADDR, 1'b0};
    localparam logic [7:0] RD = {accessory_regs_pkg::BUS_ADDR, 1'b1};
    // Stimulus
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] first_src = 8'h00;
    accessory_regs_pkg::second_src_t second_src = '0;
    logic adc_irq_disable = 1'b0;
    logic adc_start = 1'b0;
    logic [4:0] adc_sample = 5'h00;
    logic [2:0] timing_start = 3'h0;
    // Outputs and bus lines; the pull-up wins unless someone pulls low
    logic sda_out, sda_oe, second_pending, scl, sda_low, rd_valid, sda_line, ack;
    logic [7:0] first_report, rd_byte, t1, t2, m1;
    logic [2:0] timing_done;
    logic [7:0] exp_q[$];
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    assign sda_line = !(sda_low || sda_oe);
    accessory_irq_timing_regs #(.TICK_CYCLES(TICK)) accessory_irq_timing_regs_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .first_src(first_src), .first_report(first_report),
        .second_src(second_src), .adc_irq_disable(adc_irq_disable),
        .second_pending(second_pending), .adc_start(adc_start), .adc_sample(adc_sample),
        .timing_start(timing_start), .timing_done(timing_done));
    host_model host_model_inst (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low), .rd_valid(rd_valid), .rd_byte(rd_byte));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Longest run is well under this; reaching it means a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    // Each byte read is matched against the oldest note
    always @(posedge sys_clk) begin
        if (rd_valid) begin
            check(rd_byte, exp_q.pop_front());
        end
    end
    task automatic put_ok(input logic [7:0] b);
        host_model_inst.put(b, ack);
        check({7'h00, ack}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d[$]);
        host_model_inst.start();
        put_ok(WR);
        put_ok(ofs);
        foreach (d[i]) begin
            put_ok(d[i]);
        end
        host_model_inst.stop();
    endtask
    // Sets the pointer, then reads cnt bytes noted in exp_q beforehand
    task automatic rd(input logic [7:0] ofs, input int cnt);
        logic [7:0] b;
        host_model_inst.start();
        put_ok(WR);
        put_ok(ofs);
        host_model_inst.start();
        put_ok(RD);
        for (int i = 0; i < cnt; i++) begin
            host_model_inst.get(i == cnt - 1, b);
        end
        host_model_inst.stop();
    endtask
    // Kind 0..2 are the timers, 3 is detection seen through the flag
    task automatic timed(input int kind, input logic [3:0] code);
        int cnt;
        int lim;
        cnt = 0;
        lim = 50 * (code + 1) * TICK;
        if (kind == 3) begin
            adc_start = 1'b1;
        end else begin
            timing_start[kind] = 1'b1;
        end
        @(negedge sys_clk);
        adc_start = 1'b0;
        timing_start = 3'h0;
        while (cnt < 4000 && !(kind == 3 ? second_pending : timing_done[kind])) begin
            @(negedge sys_clk);
            cnt++;
        end
        check({7'h00, cnt >= lim - TICK - 2 && cnt <= lim + TICK}, 8'h01);
    endtask
    task automatic pulse_second();
        second_src = 3'b111;
        @(negedge sys_clk);
        second_src = 3'b000;
        @(negedge sys_clk);
    endtask
    initial begin
        void'($urandom(32'h87c7));
        t1 = 8'($urandom);
        t2 = 8'($urandom);
        m1 = 8'($urandom);
        adc_sample = 5'($urandom);
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        // Reset values, ending on the unmapped place after the block
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};
        rd(8'h04, 7);
        $display("test 1 done");
        // Writes to flags and to the code are dropped
        wr(8'h04, '{8'hff, 8'h00, 8'h00, 8'haa, t1, t2});
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h1f, t1, t2};
        rd(8'h04, 6);
        $display("test 2 done");
        timed(0, t1[7:4]);
        timed(1, t2[3:0]);
        timed(2, t2[7:4]);
        timed(3, t1[3:0]);
        $display("test 3 done");
        // Stuck and attach events join the detection flag; one read clears all
        pulse_second();
        exp_q = '{8'h1e, 8'h00, 8'h00, {3'h0, adc_sample}};
        rd(8'h04, 4);
        exp_q = '{8'h00};
        rd(8'h04, 1);
        check({7'h00, second_pending}, 8'h00);
        $display("test 4 done");
        // Host keeps reserved mask bits at zero
        wr(8'h05, '{m1, 8'h1e});
        exp_q = '{m1, 8'h1e};
        rd(8'h05, 2);
        for (int i = 0; i < 8; i++) begin
            first_src = 8'($urandom);
            @(negedge sys_clk);
            check(first_report, first_src & ~m1);
        end
        first_src = 8'h00;
        pulse_second();
        check({7'h00, second_pending}, 8'h00);
        $display("test 5 done");
        // Disabled detection interrupt still refreshes the code
        wr(8'h06, '{8'h00});
        adc_irq_disable = 1'b1;
        adc_sample = ~adc_sample;
        adc_start = 1'b1;
        @(negedge sys_clk);
        adc_start = 1'b0;
        repeat (50 * (t1[3:0] + 1) * TICK + 8) @(negedge sys_clk);
        exp_q = '{8'h00, m1, 8'h00, {3'h0, adc_sample}};
        rd(8'h04, 4);
        $display("test 6 done");
        complete_run();
    end
endmodule

`default_nettype wire
